// *** common/pric_defines.vh ***
// Constants shared by the priority interrupt controller files.
`ifndef PRIC_DEFINES_VH
`define PRIC_DEFINES_VH
`define PRIC_NSRC 54
`define PRIC_NPRIO_REGS 11
`define PRIC_PRIO_IDX_W 4
`define PRIC_NTRAP 4
`define PRIC_NEXT 3
`define PRIC_EXT0_SRC 0
`define PRIC_EXT1_SRC 16
`define PRIC_EXT2_SRC 23
`define PRIC_NEST_DIS_BIT 15
`define PRIC_ADDR_ERR_BIT 3
`define PRIC_ALT_TABLE_BIT 15
`define PRIC_TIMED_BLK_BIT 14
`define PRIC_EXCP_WMASK 16'h801F
`define PRIC_EXT_WMASK 16'h8007
`define PRIC_EXCP_RESET 16'h0000
`define PRIC_EXT_RESET 16'h0000
`define PRIC_IPL_RESET 4'h0
`define PRIC_PRIO_RESET 16'h4444
`define PRIC_PRIO_NIBBLE_MASK 16'h7777
`define PRIC_TIMED_BLK_MAX_LVL 3'h6
`define PRIC_SRC_VECTOR_OFS 24'h000008
`define PRIC_PRIMARY_BASE 24'h000004
`define PRIC_ALT_BASE 24'h000084
`define PRIC_VECTOR_SPACE_LO 24'h000004
`define PRIC_VECTOR_SPACE_HI 24'h0000FE
`define PRIC_COUNT_W 14
`define PRIC_COUNT_ZERO 14'h0000
`define PRIC_COUNT_ONE 14'h0001
`define PRIC_ADDR_ZERO 24'h000000
`endif

// *** logic/pric_arbiter.v ***
// Combinational winner search over pending sources by level, then natural order.
`timescale 1ns/1ps
`include "pric_defines.vh"
module pric_arbiter (
    // Candidates
    input wire [`PRIC_NSRC-1:0] cand_i,
    input wire [`PRIC_NSRC*3-1:0] level_i,
    // Winner
    output wire win_valid_o,
    output wire [5:0] win_id_o,
    output wire [2:0] win_level_o
);
    wire [`PRIC_NSRC:0] valid_chain;
    wire [6*(`PRIC_NSRC+1)-1:0] id_chain;
    wire [3*(`PRIC_NSRC+1)-1:0] lvl_chain;

    assign valid_chain[`PRIC_NSRC] = 1'b0;
    assign id_chain[6*`PRIC_NSRC +: 6] = 6'h00;
    assign lvl_chain[3*`PRIC_NSRC +: 3] = 3'h0;

    // The chain runs from the last source down, so a lower number wins a tie.
    genvar g;
    generate
        for (g = 0; g < `PRIC_NSRC; g = g + 1) begin : g_stage
            wire take;
            wire [31:0] src_num;
            assign src_num = g;
            assign take = cand_i[g] && (!valid_chain[g+1] ||
                          level_i[3*g +: 3] >= lvl_chain[3*(g+1) +: 3]);
            assign valid_chain[g] = valid_chain[g+1] | cand_i[g];
            assign id_chain[6*g +: 6] = take ? src_num[5:0] : id_chain[6*(g+1) +: 6];
            assign lvl_chain[3*g +: 3] = take ? level_i[3*g +: 3] : lvl_chain[3*(g+1) +: 3];
        end
    endgenerate

    assign win_valid_o = valid_chain[0];
    assign win_id_o = id_chain[5:0];
    assign win_level_o = lvl_chain[2:0];
endmodule // pric_arbiter

// *** logic/pric_controller.v ***
// Priority interrupt controller: flags, enables, priorities, vectoring, vector-space guard.
// Operation
// - arbitrate 44 sources; 4 traps only set exception bits
// - peripherals set flags, software alone clears
// - flags set regardless of enable
// - per-source enable gates arbitration
// - eleven priority registers hold source levels
// - levels 1 to 7, 7 highest
// - level zero behaves as disabled
// - CPU level four bits, top bit separate
// - nesting disable blocks new interrupts in service
// - nesting disable makes CPU level read-only
// - timed block masks levels 6 and below
// - exception control and external control registers
// - edge and level options live in peripherals
// - PC loaded with 24-bit vector contents
// - 62 vectors per table, 0x000004 to 0x0000FE
// - fetch from vector space raises address error
// - jump into vector space raises address error
// - low three bits of each nibble; top zero
// - equal levels resolved by lower source number
// - traps levels 8 to 15, top bit set
// - CPU level 7 masks all maskable interrupts
`timescale 1ns/1ps
`include "pric_defines.vh"
module pric_controller (
    // Clock and reset
    input wire clk_i,
    input wire srst_i,
    // Interrupt sources
    input wire [`PRIC_NSRC-1:0] src_event_i,
    input wire [`PRIC_NEXT-1:0] ext_pin_i,
    input wire [`PRIC_NTRAP-1:0] trap_event_i,
    // Software control
    input wire [`PRIC_NSRC-1:0] flag_clr_i,
    input wire [`PRIC_NSRC-1:0] src_enable_i,
    input wire prio_wr_i,
    input wire [`PRIC_PRIO_IDX_W-1:0] prio_idx_i,
    input wire [15:0] prio_data_i,
    input wire ipl_wr_i,
    input wire [3:0] ipl_data_i,
    input wire excp_wr_i,
    input wire [15:0] excp_data_i,
    input wire ext_wr_i,
    input wire [15:0] ext_data_i,
    input wire timed_blk_start_i,
    input wire [`PRIC_COUNT_W-1:0] timed_blk_count_i,
    input wire instr_done_i,
    // Core vectoring handshake
    input wire irq_ack_i,
    input wire prog_data_valid_i,
    input wire [23:0] prog_data_i,
    input wire isr_return_i,
    // Core execution monitor
    input wire fetch_valid_i,
    input wire [23:0] fetch_addr_i,
    input wire goto_valid_i,
    input wire [23:0] goto_target_i,
    // Status and results
    output reg [`PRIC_NSRC-1:0] request_flag_o,
    output reg [3:0] cpu_priority_level_o,
    output reg [15:0] exception_control_reg_o,
    output reg [15:0] external_irq_control_reg_o,
    output reg [15:0] prio_rd_o,
    output reg irq_req_o,
    output reg [2:0] irq_level_o,
    output reg [5:0] irq_src_o,
    output reg vec_fetch_o,
    output reg [23:0] vec_addr_o,
    output reg pc_load_o,
    output reg [23:0] pc_value_o,
    output reg addr_err_trap_o,
    output reg in_service_o
);
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_REQ = 4'h2;
    localparam [3:0] ST_FETCH = 4'h4;
    localparam [3:0] ST_LOAD = 4'h8;

    reg [15:0] priority_cfg_regs [0:`PRIC_NPRIO_REGS-1];
    reg [3:0] state;
    reg [3:0] next_state;
    reg [`PRIC_NEXT-1:0] ext_meta;
    reg [`PRIC_NEXT-1:0] ext_sync;
    reg [`PRIC_NEXT-1:0] ext_prev;
    reg [`PRIC_COUNT_W-1:0] timed_blk_left;
    reg [5:0] held_src;
    reg [`PRIC_NSRC-1:0] ext_evt;
    reg [`PRIC_NSRC-1:0] cand;
    reg [`PRIC_NSRC*3-1:0] level_flat;
    reg [3:0] next_ipl;
    reg [15:0] next_excp;
    wire win_valid;
    wire [5:0] win_id;
    wire [2:0] win_level;
    wire nesting_disable;
    wire timed_low_priority_block;
    wire [`PRIC_NEXT-1:0] ext_edge;
    wire fetch_guard;
    wire goto_guard;
    wire [24:0] vec_ofs_x2;
    integer i;

    // Vector space covers both tables; fetches issued by this block are exempt.
    function in_vector_space;
        input [23:0] addr;
        begin
            in_vector_space = addr >= `PRIC_VECTOR_SPACE_LO && addr <= `PRIC_VECTOR_SPACE_HI;
        end
    endfunction

    assign nesting_disable = exception_control_reg_o[`PRIC_NEST_DIS_BIT];
    assign timed_low_priority_block = timed_blk_left != `PRIC_COUNT_ZERO;
    assign vec_ofs_x2 = {`PRIC_SRC_VECTOR_OFS, 1'b0};

    // Pins cross into the clock domain before edge detection.
    always @(posedge clk_i) begin
        if (srst_i) begin
            ext_meta <= 3'h0;
            ext_sync <= 3'h0;
            ext_prev <= 3'h0;
        end else begin
            ext_meta <= ext_pin_i;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    // external control picks the active edge per pin
    assign ext_edge = (ext_sync ^ ext_prev) & (ext_sync ^ external_irq_control_reg_o[2:0]);

    always @* begin
        ext_evt = {`PRIC_NSRC{1'b0}};
        ext_evt[`PRIC_EXT0_SRC] = ext_edge[0];
        ext_evt[`PRIC_EXT1_SRC] = ext_edge[1];
        ext_evt[`PRIC_EXT2_SRC] = ext_edge[2];
    end

    // set by events, cleared by software; set wins
    always @(posedge clk_i) begin
        if (srst_i) begin
            request_flag_o <= {`PRIC_NSRC{1'b0}};
        end else begin
            request_flag_o <= (request_flag_o & ~flag_clr_i) | src_event_i | ext_evt;
        end
    end

    // top bit of each nibble kept zero
    always @(posedge clk_i) begin
        if (srst_i) begin
            for (i = 0; i < `PRIC_NPRIO_REGS; i = i + 1) begin
                priority_cfg_regs[i] <= `PRIC_PRIO_RESET;
            end
        end else if (prio_wr_i && prio_idx_i < `PRIC_NPRIO_REGS) begin
            priority_cfg_regs[prio_idx_i] <= prio_data_i & `PRIC_PRIO_NIBBLE_MASK;
        end
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            prio_rd_o <= 16'h0000;
        end else if (prio_idx_i < `PRIC_NPRIO_REGS) begin
            prio_rd_o <= priority_cfg_regs[prio_idx_i];
        end else begin
            prio_rd_o <= 16'h0000;
        end
    end

    // Sources beyond the eleven registers have no level and therefore never win.
    always @* begin
        level_flat = {(`PRIC_NSRC*3){1'b0}};
        for (i = 0; i < `PRIC_NPRIO_REGS * 4; i = i + 1) begin
            level_flat[3*i +: 3] = priority_cfg_regs[i / 4][4*(i % 4) +: 3];
        end
    end

    // timed block masks 6 and below
    always @* begin
        for (i = 0; i < `PRIC_NSRC; i = i + 1) begin
            cand[i] = request_flag_o[i] && src_enable_i[i] &&
                      level_flat[3*i +: 3] != 3'h0 &&
                      {1'b0, level_flat[3*i +: 3]} > cpu_priority_level_o &&
                      !(timed_low_priority_block &&
                        level_flat[3*i +: 3] <= `PRIC_TIMED_BLK_MAX_LVL);
        end
    end

    pric_arbiter u_arbiter (
        .cand_i(cand),
        .level_i(level_flat),
        .win_valid_o(win_valid),
        .win_id_o(win_id),
        .win_level_o(win_level)
    );

    // CPU level frozen under nesting disable
    // four-bit level, core writes both parts
    always @* begin
        next_ipl = cpu_priority_level_o;
        if (ipl_wr_i && !nesting_disable) begin
            next_ipl = ipl_data_i;
        end
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            cpu_priority_level_o <= `PRIC_IPL_RESET;
        end else begin
            cpu_priority_level_o <= next_ipl;
        end
    end

    assign fetch_guard = fetch_valid_i && in_vector_space(fetch_addr_i) && !vec_fetch_o;
    assign goto_guard = goto_valid_i && in_vector_space(goto_target_i);

    // exception flags, set wins over a software write
    always @* begin
        next_excp = exception_control_reg_o;
        if (excp_wr_i) begin
            next_excp = excp_data_i & `PRIC_EXCP_WMASK;
        end
        next_excp[`PRIC_NTRAP:1] = next_excp[`PRIC_NTRAP:1] | trap_event_i;
        if (fetch_guard || goto_guard) begin
            next_excp[`PRIC_ADDR_ERR_BIT] = 1'b1;
        end
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            exception_control_reg_o <= `PRIC_EXCP_RESET;
            addr_err_trap_o <= 1'b0;
        end else begin
            exception_control_reg_o <= next_excp;
            addr_err_trap_o <= fetch_guard || goto_guard;
        end
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            timed_blk_left <= `PRIC_COUNT_ZERO;
        end else if (timed_blk_start_i) begin
            timed_blk_left <= timed_blk_count_i;
        end else if (instr_done_i && timed_low_priority_block) begin
            timed_blk_left <= timed_blk_left - `PRIC_COUNT_ONE;
        end
    end

    always @(posedge clk_i) begin
        if (srst_i) begin
            external_irq_control_reg_o <= `PRIC_EXT_RESET;
        end else begin
            if (ext_wr_i) begin
                external_irq_control_reg_o <= ext_data_i & `PRIC_EXT_WMASK;
            end
            external_irq_control_reg_o[`PRIC_TIMED_BLK_BIT] <=
                timed_blk_start_i ? (timed_blk_count_i != `PRIC_COUNT_ZERO) :
                (timed_low_priority_block &&
                 !(instr_done_i && timed_blk_left == `PRIC_COUNT_ONE));
        end
    end

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                // no new interrupt while one is served with nesting disabled
                if (win_valid && !(nesting_disable && in_service_o)) begin
                    next_state = ST_REQ;
                end
            end
            ST_REQ: begin
                if (irq_ack_i) begin
                    next_state = ST_FETCH;
                end else if (!cand[held_src]) begin
                    next_state = ST_IDLE;
                end
            end
            ST_FETCH: begin
                if (prog_data_valid_i) begin
                    next_state = ST_LOAD;
                end
            end
            ST_LOAD: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // one request presented at a time
    always @(posedge clk_i) begin
        if (srst_i) begin
            state <= ST_IDLE;
            held_src <= 6'h00;
            irq_req_o <= 1'b0;
            irq_level_o <= 3'h0;
            irq_src_o <= 6'h00;
            vec_fetch_o <= 1'b0;
            vec_addr_o <= `PRIC_ADDR_ZERO;
            pc_load_o <= 1'b0;
            pc_value_o <= `PRIC_ADDR_ZERO;
            in_service_o <= 1'b0;
        end else begin
            state <= next_state;
            pc_load_o <= 1'b0;
            if (state == ST_IDLE && next_state == ST_REQ) begin
                held_src <= win_id;
                irq_src_o <= win_id;
                irq_level_o <= win_level;
                irq_req_o <= 1'b1;
            end
            if (state == ST_REQ && next_state != ST_REQ) begin
                irq_req_o <= 1'b0;
            end
            if (state == ST_REQ && irq_ack_i) begin
                // entry address is base plus two per vector
                vec_addr_o <= (external_irq_control_reg_o[`PRIC_ALT_TABLE_BIT] ?
                               `PRIC_ALT_BASE : `PRIC_PRIMARY_BASE) +
                              {17'h00000, held_src, 1'b0} + vec_ofs_x2[23:0];
                vec_fetch_o <= 1'b1;
                in_service_o <= 1'b1;
            end
            if (state == ST_FETCH && prog_data_valid_i) begin
                // vector contents go to the PC
                pc_value_o <= prog_data_i;
                pc_load_o <= 1'b1;
                vec_fetch_o <= 1'b0;
            end
            if (isr_return_i && !(state == ST_REQ && irq_ack_i)) begin
                in_service_o <= 1'b0;
            end
        end
    end
endmodule // pric_controller

// *** sim/pric_monitor.sv ***
// Concurrent checks on the interrupt controller ports.
`timescale 1ns/1ps
`include "pric_defines.vh"
module pric_monitor (
    // Clock and reset
    input wire clk_i,
    input wire srst_i,
    // Inputs
    input wire [`PRIC_NSRC-1:0] src_event_i,
    input wire [`PRIC_NSRC-1:0] flag_clr_i,
    input wire ipl_wr_i,
    input wire irq_ack_i,
    input wire prog_data_valid_i,
    input wire [23:0] prog_data_i,
    input wire fetch_valid_i,
    input wire [23:0] fetch_addr_i,
    input wire goto_valid_i,
    input wire [23:0] goto_target_i,
    // Outputs
    input wire [`PRIC_NSRC-1:0] request_flag_o,
    input wire [3:0] cpu_priority_level_o,
    input wire [15:0] exception_control_reg_o,
    input wire [15:0] external_irq_control_reg_o,
    input wire irq_req_o,
    input wire [2:0] irq_level_o,
    input wire [5:0] irq_src_o,
    input wire vec_fetch_o,
    input wire [23:0] vec_addr_o,
    input wire pc_load_o,
    input wire [23:0] pc_value_o,
    input wire addr_err_trap_o,
    input wire in_service_o
);
    wire f_in = fetch_addr_i >= 24'h000004 && fetch_addr_i <= 24'h0000FE;
    wire g_in = goto_target_i >= 24'h000004 && goto_target_i <= 24'h0000FE;
    wire [23:0] base = external_irq_control_reg_o[15] ? 24'h000084 : 24'h000004;
    wire [23:0] exp_vec = base + {16'h0000, {1'b0, irq_src_o} + 7'h08, 1'b0};
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    property p_flag_set; 1 |=> &(request_flag_o | ~$past(src_event_i)); endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");
    property p_flag_hold; 1 |=> &(request_flag_o | ~$past(request_flag_o) | $past(flag_clr_i)); endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
    property p_vec; irq_req_o && irq_ack_i |=> vec_fetch_o && in_service_o && vec_addr_o == $past(exp_vec); endproperty
    a_vec: assert property (p_vec) else $error("bad vector fetch");
    property p_pc; vec_fetch_o && prog_data_valid_i |=> pc_load_o && pc_value_o == $past(prog_data_i); endproperty
    a_pc: assert property (p_pc) else $error("bad pc load");
    property p_fetch; fetch_valid_i && !vec_fetch_o && f_in |=> addr_err_trap_o && exception_control_reg_o[3]; endproperty
    a_fetch: assert property (p_fetch) else $error("no fetch trap");
    property p_goto; goto_valid_i && g_in |=> addr_err_trap_o; endproperty
    a_goto: assert property (p_goto) else $error("no jump trap");
    property p_nest; exception_control_reg_o[15] && in_service_o |=> !$rose(irq_req_o); endproperty
    a_nest: assert property (p_nest) else $error("nested request");
    property p_ipl_ro; exception_control_reg_o[15] && ipl_wr_i |=> $stable(cpu_priority_level_o); endproperty
    a_ipl_ro: assert property (p_ipl_ro) else $error("level written");
    property p_level; $rose(irq_req_o) |-> {1'b0, irq_level_o} > $past(cpu_priority_level_o); endproperty
    a_level: assert property (p_level) else $error("level too low");
    property p_timed; $rose(irq_req_o) && $past(external_irq_control_reg_o[14]) |-> irq_level_o == 3'h7; endproperty
    a_timed: assert property (p_timed) else $error("blocked level taken");
endmodule // pric_monitor

// *** sim/pric_core_model.sv ***
// Core model: accepts requests and returns vector words, with a settable wait.
`timescale 1ns/1ps
module pric_core_model (
    // Clock and reset
    input wire clk_i,
    input wire srst_i,
    // Controller side
    input wire irq_req_i,
    input wire vec_fetch_i,
    input wire [23:0] vec_addr_i,
    input wire [1:0] wait_i,
    output reg irq_ack_o,
    output reg prog_data_valid_o,
    output reg [23:0] prog_data_o
);
    reg [1:0] wa;
    reg [1:0] wd;
    always @(posedge clk_i) begin
        if (srst_i || !irq_req_i || irq_ack_o) begin
            irq_ack_o <= 1'b0;
            wa <= 2'h0;
        end else if (wa == wait_i) begin
            irq_ack_o <= 1'b1;
        end else begin
            wa <= wa + 2'h1;
        end
        if (srst_i || !vec_fetch_i || prog_data_valid_o) begin
            prog_data_valid_o <= 1'b0;
            wd <= 2'h0;
            // Released data is scrambled so a stale word cannot pass.
            prog_data_o <= srst_i ? 24'h000000 : ~prog_data_o;
        end else if (wd == wait_i) begin
            prog_data_valid_o <= 1'b1;
            prog_data_o <= vec_addr_i + 24'h100000;
        end else begin
            wd <= wd + 2'h1;
        end
    end
endmodule // pric_core_model

// *** sim/priority_interrupt_controller_tb_top.sv ***
// Self-checking bench for the priority interrupt controller.
`timescale 1ns/1ps
`include "pric_defines.vh"
module priority_interrupt_controller_tb_top;
    reg clk_i = 1'b0, srst_i = 1'b1;
    reg [`PRIC_NSRC-1:0] src_event_i = '0, flag_clr_i = '0, src_enable_i = '0;
    reg [2:0] ext_pin_i = '0;
    reg [3:0] trap_event_i = '0, ipl_data_i = '0, prio_idx_i = '0;
    reg prio_wr_i = 0, ipl_wr_i = 0, excp_wr_i = 0, ext_wr_i = 0, timed_blk_start_i = 0;
    reg instr_done_i = 0, isr_return_i = 0, fetch_valid_i = 0, goto_valid_i = 0, alt = 0;
    reg [15:0] prio_data_i = '0, excp_data_i = '0, ext_data_i = '0;
    reg [`PRIC_COUNT_W-1:0] timed_blk_count_i = '0;
    reg [23:0] fetch_addr_i = '0, goto_target_i = '0, a;
    reg [1:0] wt = 2'h0;
    wire irq_ack_i, prog_data_valid_i, irq_req_o, vec_fetch_o, pc_load_o;
    wire addr_err_trap_o, in_service_o;
    wire [23:0] prog_data_i, vec_addr_o, pc_value_o;
    wire [`PRIC_NSRC-1:0] request_flag_o;
    wire [3:0] cpu_priority_level_o;
    wire [15:0] exception_control_reg_o, external_irq_control_reg_o, prio_rd_o;
    wire [2:0] irq_level_o;
    wire [5:0] irq_src_o;
    integer errors = 0, n_compared = 0, i, k, s;
    reg [23:0] expq[$];
    pric_controller uut (.*);
    pric_core_model core (.clk_i(clk_i), .srst_i(srst_i), .irq_req_i(irq_req_o),
        .vec_fetch_i(vec_fetch_o), .vec_addr_i(vec_addr_o), .wait_i(wt),
        .irq_ack_o(irq_ack_i), .prog_data_valid_o(prog_data_valid_i), .prog_data_o(prog_data_i));
    always #50 clk_i = ~clk_i;
    task automatic cmp(input string nm, input [63:0] e, input [63:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
        end
    endtask
    task finish_test;
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    function automatic [23:0] epc(input integer src);
        epc = (alt ? `PRIC_ALT_BASE : `PRIC_PRIMARY_BASE) + 24'h100010 + {src[22:0], 1'b0};
    endfunction
    task automatic wr(input integer w, input [15:0] d);
        @(negedge clk_i);
        {ipl_data_i, excp_data_i, ext_data_i} = {d[3:0], d, d};
        {ipl_wr_i, excp_wr_i, ext_wr_i} = {w == 0, w == 1, w == 2};
        @(negedge clk_i);
        {ipl_wr_i, excp_wr_i, ext_wr_i} = 3'h0;
    endtask
    task automatic raise(input integer src, input [2:0] lvl);
        @(negedge clk_i);
        prio_idx_i = src[5:2];
        prio_data_i = {13'h0000, lvl} << (4 * src[1:0]);
        {prio_wr_i, src_event_i[src]} = 2'h3;
        @(negedge clk_i);
        {prio_wr_i, src_event_i[src]} = 2'h0;
        @(negedge clk_i);
        cmp("flag", 1'b1, request_flag_o[src]);
        cmp("irq_req", 1'b0, irq_req_o);
        flag_clr_i[src] = 1'b1;
        @(negedge clk_i);
        flag_clr_i[src] = 1'b0;
        {src_enable_i[src], src_event_i[src]} = 2'h3;
        @(negedge clk_i);
        src_event_i[src] = 1'b0;
    endtask
    task automatic wait_pc(input integer src);
        k = 0;
        while (pc_load_o !== 1'b1 && k < 60) begin
            @(negedge clk_i);
            k++;
        end
        cmp("pc_load", 1'b1, pc_load_o);
        {flag_clr_i[src], src_enable_i[src]} = 2'h2;
        @(negedge clk_i);
        flag_clr_i[src] = 1'b0;
    endtask
    task automatic done;
        @(negedge clk_i) isr_return_i = 1'b1;
        @(negedge clk_i) isr_return_i = 1'b0;
    endtask
    always @(negedge clk_i)
        if (pc_load_o === 1'b1)
            cmp("pc_value", (expq.size() > 0) ? expq.pop_front() : 24'hXXXXXX, pc_value_o);
    initial begin
        #2000000;
        errors++;
        finish_test;
    end
    initial begin
        s = $urandom(73988);
        repeat (8) @(negedge clk_i);
        srst_i = 1'b0;
        @(negedge clk_i);
        cmp("prio_rd", 16'h4444, prio_rd_o);
        cmp("cpu_level", 4'h0, cpu_priority_level_o);
        expq.push_back(epc(41));
        raise(41, 3'h7);
        wait_pc(41);
        @(negedge clk_i) {prio_data_i, prio_wr_i} = {16'hFFFF, 1'b1};
        @(negedge clk_i) prio_wr_i = 1'b0;
        @(negedge clk_i);
        cmp("prio_rd", 16'h7777, prio_rd_o);
        for (i = 0; i < 12; i++) begin
            s = $urandom % 44;
            alt = i[0];
            wt = $urandom;
            wr(2, {alt, 15'h0000});
            expq.push_back(epc(s));
            raise(s, 3'h1 + $urandom % 7);
            wait_pc(s);
            done;
        end
        // Both pending together at the top level, lower number wins.
        s = ($urandom % 40) & 32'hFFFFFFFB;
        wr(0, 16'h0007);
        raise(s, 3'h7);
        raise(s + 4, 3'h7);
        cmp("irq_req", 1'b0, irq_req_o);
        expq.push_back(epc(s));
        expq.push_back(epc(s + 4));
        wr(0, 16'h0006);
        wait_pc(s);
        wait_pc(s + 4);
        done;
        wr(0, 16'h0000);
        wr(1, 16'h8000);
        wr(0, 16'h0005);
        cmp("cpu_level", 4'h0, cpu_priority_level_o);
        expq.push_back(epc(s));
        raise(s, 3'h2);
        wait_pc(s);
        expq.push_back(epc(s ^ 4));
        raise(s ^ 4, 3'h7);
        cmp("irq_req", 1'b0, irq_req_o);
        done;
        wait_pc(s ^ 4);
        done;
        wr(1, 16'h0000);
        @(negedge clk_i);
        {timed_blk_count_i, timed_blk_start_i} = {14'h0003, 1'b1};
        @(negedge clk_i);
        timed_blk_start_i = 1'b0;
        cmp("timed_bit", 1'b1, external_irq_control_reg_o[14]);
        expq.push_back(epc(s ^ 4));
        expq.push_back(epc(s));
        raise(s, 3'h6);
        raise(s ^ 4, 3'h7);
        wait_pc(s ^ 4);
        done;
        cmp("irq_req", 1'b0, irq_req_o);
        repeat (3) begin
            @(negedge clk_i) instr_done_i = 1'b1;
            @(negedge clk_i) instr_done_i = 1'b0;
        end
        cmp("timed_bit", 1'b0, external_irq_control_reg_o[14]);
        wait_pc(s);
        done;
        raise(s, 3'h0);
        repeat (4) @(negedge clk_i);
        cmp("irq_req", 1'b0, irq_req_o);
        src_enable_i[s] = 1'b0;
        for (i = 0; i < 8; i++) begin
            case (i[1:0])
                2'h0: a = i[2] ? 24'h000003 : 24'h0000FF;
                2'h1: a = 24'h000004;
                2'h2: a = 24'h0000FE;
                default: a = $urandom % 512;
            endcase
            @(negedge clk_i);
            {fetch_valid_i, goto_valid_i, fetch_addr_i, goto_target_i} = {!i[2], i[2], a, a};
            @(negedge clk_i);
            {fetch_valid_i, goto_valid_i} = 2'h0;
            cmp("addr_err", a >= 24'h000004 && a <= 24'h0000FE, addr_err_trap_o);
        end
        cmp("err_bit", 1'b1, exception_control_reg_o[3]);
        for (i = 0; i < 4; i++) begin
            @(negedge clk_i) trap_event_i[i] = 1'b1;
            @(negedge clk_i) trap_event_i[i] = 1'b0;
        end
        cmp("trap_bits", 4'hF, exception_control_reg_o[4:1]);
        wr(1, 16'h0000);
        cmp("excp_reg", 16'h0000, exception_control_reg_o);
        ext_pin_i = 3'h7;
        repeat (6) @(negedge clk_i);
        cmp("pin_flags", 3'h7, {request_flag_o[23], request_flag_o[16], request_flag_o[0]});
        // Falling-edge polarity: flags are cleared first so only the drop can set them.
        flag_clr_i = '1;
        wr(2, 16'h0007);
        flag_clr_i = '0;
        @(negedge clk_i);
        cmp("pin_quiet", 3'h0, {request_flag_o[23], request_flag_o[16], request_flag_o[0]});
        ext_pin_i = 3'h0;
        repeat (6) @(negedge clk_i);
        cmp("pin_fall", 3'h7, {request_flag_o[23], request_flag_o[16], request_flag_o[0]});
        repeat (4) @(negedge clk_i);
        cmp("queue_left", 0, expq.size());
        finish_test;
    end
endmodule // priority_interrupt_controller_tb_top
bind pric_controller pric_monitor u_mon (.*);
